// ==== hdl/tdm_slot_transparent_serial.v ====
// Contract
// RQ1: Idle channel sends all-ones in its slot
// RQ2: Shift one bit per slot clock, freeze between
// RQ3: Receiver clocked only inside its slot
// RQ4: Slot start after request sends FF then data
// RQ5: Chained buffers go back to back, one FF
// RQ6: Request asserts within 36 clocks after enable
// RQ7: Software follows halt, resume, synchronized enable order
// RQ8: Synchronized enable fills FIFO in fixed time
// RQ9: Enable inside slot works given 36 clocks
// RQ10: Highway first channel request has inverted polarity
// RQ11: Short slots add extra all-ones slots first
// RQ12: Reception starts at first slot after enable
// RQ13: Received word written ninth slot clock later
// RQ14: Software sets sync bits; diag either mode
// RQ15: Carrier and clear-send status read zero enabled; code reads zero only in highway mode
// RQ16: Line quiet flag has no meaning here
// RQ17: Extra clock shifts alignment until resync
// RQ18: Bearer channels and subportions via slot mask
// RQ19: Byte aligned start at bearer channel begin
// RQ20: Combined bearers start consistently with sync enable
// RQ21: Slot code zero none, one to three channels
// RQ22: Slot rising edge gates clocks, sends sync
// RQ23: One-clock-prior and envelope slot timing
// RQ24: Request held until whole frame sent
`timescale 1ns/1ps
`include "tdm_slot_defines.vh"

module tdm_slot_transparent_serial (
    input wire core_clk,
    input wire rst_n,
    input wire [3:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdata,
    input wire highway_bit_clock,
    input wire slot_select_low,
    input wire slot_select_high,
    input wire rxSerial,
    output reg txSerial,
    output reg first_channel_tx_request
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    reg [2:0] clkSync;
    reg [2:0] selLoSync;
    reg [2:0] selHiSync;
    reg [2:0] rxSync;
    reg linkClk;
    reg selLo;
    reg selHi;
    reg rxBit;

    // A change counts once stages two and three agree
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkSync <= 3'h0;
            selLoSync <= 3'h0;
            selHiSync <= 3'h0;
            rxSync <= 3'h7;
            linkClk <= 1'b0;
            selLo <= 1'b0;
            selHi <= 1'b0;
            rxBit <= 1'b1;
        end else begin
            clkSync <= {clkSync[1:0], highway_bit_clock};
            selLoSync <= {selLoSync[1:0], slot_select_low};
            selHiSync <= {selHiSync[1:0], slot_select_high};
            rxSync <= {rxSync[1:0], rxSerial};
            if (clkSync[1] == clkSync[2])
                linkClk <= clkSync[2];
            if (selLoSync[1] == selLoSync[2])
                selLo <= selLoSync[2];
            if (selHiSync[1] == selHiSync[2])
                selHi <= selHiSync[2];
            if (rxSync[1] == rxSync[2])
                rxBit <= rxSync[2];
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    reg [7:0] serial_interface_mode_reg;
    reg [7:0] slot_bit_mask_reg;
    reg transmit_enable_bit;
    reg receive_enable_bit;
    reg lastFlag;
    reg [7:0] txHold;
    reg txHoldFull;
    reg [7:0] rxHold;
    reg rxValid;
    reg txDone;

    wire highwayMode = serial_interface_mode_reg[`MODE_HIGHWAY];
    wire envelopeMode = serial_interface_mode_reg[`MODE_ENVELOPE];
    wire [1:0] route = serial_interface_mode_reg[`MODE_ROUTE_HI:`MODE_ROUTE_LO];
    wire transparent_sync_bit = serial_interface_mode_reg[`MODE_TSYNC];
    wire external_sync_bit = serial_interface_mode_reg[`MODE_XSYNC];

    // ************************************************************
    // Slot timing
    // ************************************************************
    reg linkClkQ;
    reg selActQ;
    reg priorArmed;
    reg [3:0] priorCount;
    wire [1:0] slotCode = {selHi, selLo};
    wire selAct = (route != 2'h0) && (slotCode == route); // [RQ21]
    wire clkRise = linkClk && !linkClkQ;
    wire slotStart = selAct && !selActQ; // [RQ22]
    wire inSlot = envelopeMode ? selAct : (priorCount != 4'h0); // [RQ23]
    // Only clocks inside the slot reach the channel
    wire gatedClk = clkRise && inSlot; // [RQ2] [RQ3]
    reg [2:0] bitIdx;
    wire slotMaskOk = slot_bit_mask_reg[bitIdx]; // [RQ18]
    wire chanClk = gatedClk && slotMaskOk;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            linkClkQ <= 1'b0;
            selActQ <= 1'b0;
            priorArmed <= 1'b0;
            priorCount <= 4'h0;
            bitIdx <= 3'h0;
        end else begin
            linkClkQ <= linkClk;
            selActQ <= selAct;
            if (slotStart && !envelopeMode)
                priorArmed <= 1'b1;
            // One-clock-prior: the slot is the eight clocks after the marker clock
            if (clkRise && priorArmed) begin
                priorArmed <= 1'b0;
                priorCount <= `SLOT_BITS;
            end else if (gatedClk && !envelopeMode)
                priorCount <= priorCount - 4'h1;
            if (slotStart)
                bitIdx <= 3'h0;
            else if (gatedClk)
                bitIdx <= bitIdx + 3'h1;
        end
    end

    // ************************************************************
    // Transmitter
    // ************************************************************
    localparam TX_IDLE = 4'b0001;
    localparam TX_WAIT = 4'b0010;
    localparam TX_REQ = 4'b0100;
    localparam TX_SEND = 4'b1000;

    reg [3:0] txState;
    reg [5:0] reqCount;
    reg [7:0] txShift;
    reg [2:0] txBitCnt;
    reg txRequest;
    reg byteStart;
    // Highway or both sync bits: start on a slot boundary; else start at once
    wire alignStart = (highwayMode || (transparent_sync_bit && external_sync_bit)) ?
        slotStart : 1'b1; // [RQ19]

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txState <= TX_IDLE;
            reqCount <= 6'h0;
            txShift <= `IDLE_BYTE;
            txBitCnt <= 3'h0;
            txRequest <= 1'b0;
            byteStart <= 1'b0;
            txSerial <= 1'b1;
        end else begin
            if (chanClk) begin
                txSerial <= txShift[7]; // [RQ2]
                txShift <= {txShift[6:0], 1'b1}; // [RQ1]
                txBitCnt <= txBitCnt + 3'h1;
            end
            byteStart <= chanClk && (txBitCnt == 3'h7);
            // A fresh one-clock-prior window realigns, so a stray clock spoils one byte
            if (!envelopeMode && clkRise && priorArmed && priorCount == 4'h0)
                txBitCnt <= 3'h0; // [RQ17]
            case (txState)
                TX_IDLE: begin
                    txRequest <= 1'b0;
                    reqCount <= 6'h0;
                    if (transmit_enable_bit && txHoldFull)
                        txState <= TX_WAIT;
                end
                TX_WAIT: begin
                    // Fixed fill delay makes synchronized enable repeatable
                    if (!transmit_enable_bit)
                        txState <= TX_IDLE;
                    else if (gatedClk)
                        reqCount <= reqCount + 6'h1;
                    if (transmit_enable_bit && reqCount == `REQ_DELAY_CLOCKS - 6'h1 && gatedClk) begin
                        txRequest <= 1'b1; // [RQ6] [RQ8] [RQ9]
                        txState <= TX_REQ;
                    end
                end
                TX_REQ: begin
                    // Leading all-ones byte at the next slot start when aligned, at once when not
                    if (alignStart) begin // [RQ4] [RQ11] [RQ20]
                        txShift <= `IDLE_BYTE;
                        // In envelope mode only this resync undoes a stray clock
                        txBitCnt <= 3'h0; // [RQ17]
                        txState <= TX_SEND;
                    end
                    if (!transmit_enable_bit)
                        txState <= TX_IDLE;
                end
                TX_SEND: begin
                    // Chained buffers load without another leading byte
                    if (byteStart) begin
                        if (txHoldFull)
                            txShift <= txHold; // [RQ5]
                        else begin
                            txShift <= `IDLE_BYTE; // [RQ1]
                            if (lastFlag || !transmit_enable_bit) begin
                                txRequest <= 1'b0; // [RQ24]
                                txState <= TX_IDLE;
                            end
                        end
                    end
                end
                default: txState <= TX_IDLE;
            endcase
        end
    end

    wire takeTx = (txState == TX_SEND) && byteStart && txHoldFull;

    // ************************************************************
    // Receiver
    // ************************************************************
    reg rxRunning;
    reg [7:0] rxShift;
    reg [2:0] rxBitCnt;
    reg [3:0] rxDelay;
    reg [3:0] rxAgedDelay;
    reg [7:0] rxPending;
    reg [7:0] rxAged;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxRunning <= 1'b0;
            rxShift <= 8'h00;
            rxBitCnt <= 3'h0;
            rxDelay <= 4'h0;
            rxAgedDelay <= 4'h0;
            rxPending <= 8'h00;
            rxAged <= 8'h00;
        end else begin
            if (!receive_enable_bit) begin
                // Disabling drops a half-received word
                rxRunning <= 1'b0;
                rxBitCnt <= 3'h0;
                rxDelay <= 4'h0;
                rxAgedDelay <= 4'h0;
            end else begin
                if (slotStart)
                    rxRunning <= 1'b1; // [RQ12]
                if (rxRunning && chanClk) begin
                    rxShift <= {rxShift[6:0], rxBit}; // [RQ3]
                    rxBitCnt <= rxBitCnt + 3'h1;
                    if (rxBitCnt == 3'h7) begin
                        // Next word lands before the ninth clock of the last one
                        rxAged <= rxPending;
                        rxAgedDelay <= (rxDelay != 4'h0) ? rxDelay - 4'h1 : 4'h0;
                        rxPending <= {rxShift[6:0], rxBit};
                        rxDelay <= `RX_WRITE_DELAY;
                    end else begin
                        if (rxDelay != 4'h0)
                            rxDelay <= rxDelay - 4'h1; // [RQ13]
                        if (rxAgedDelay != 4'h0)
                            rxAgedDelay <= rxAgedDelay - 4'h1;
                    end
                end
            end
        end
    end

    wire rxWrite = receive_enable_bit && rxRunning && chanClk && (rxAgedDelay == 4'h1) &&
        (rxBitCnt != 3'h7);

    // ************************************************************
    // Register port
    // ************************************************************
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        case (regAddr)
            `REG_MODE: next_rdata = serial_interface_mode_reg;
            `REG_CTRL: next_rdata = {5'h00, lastFlag, receive_enable_bit, transmit_enable_bit};
            `REG_STATUS: begin
                next_rdata[`ST_CARRIER] = !(highwayMode && receive_enable_bit); // [RQ15]
                next_rdata[`ST_CLEARSEND] = !(highwayMode && transmit_enable_bit); // [RQ15]
                next_rdata[`ST_QUIET] = 1'b0; // [RQ16]
                next_rdata[`ST_TXREQ] = txRequest;
                next_rdata[`ST_TXRDY] = !txHoldFull;
                next_rdata[`ST_RXVALID] = rxValid;
                next_rdata[`ST_TXDONE] = txDone;
            end
            `REG_TXDATA: next_rdata = txHold;
            `REG_RXDATA: next_rdata = rxHold;
            `REG_MASK: next_rdata = slot_bit_mask_reg;
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_interface_mode_reg <= `MODE_RESET;
            slot_bit_mask_reg <= `MASK_RESET;
            transmit_enable_bit <= 1'b0;
            receive_enable_bit <= 1'b0;
            lastFlag <= 1'b0;
            txHold <= 8'h00;
            txHoldFull <= 1'b0;
            rxHold <= 8'h00;
            rxValid <= 1'b0;
            txDone <= 1'b0;
            regRdata <= 8'h00;
            first_channel_tx_request <= 1'b1;
        end else begin
            regRdata <= regRead ? next_rdata : 8'h00;
            if (regWrite && regAddr == `REG_MODE)
                serial_interface_mode_reg <= regWdata;
            if (regWrite && regAddr == `REG_MASK)
                slot_bit_mask_reg <= regWdata;
            if (regWrite && regAddr == `REG_CTRL) begin
                transmit_enable_bit <= regWdata[`CTRL_TXEN];
                receive_enable_bit <= regWdata[`CTRL_RXEN];
                lastFlag <= regWdata[`CTRL_LAST];
            end
            // A write in the take cycle queues the next byte
            if (regWrite && regAddr == `REG_TXDATA) begin
                txHold <= regWdata;
                txHoldFull <= 1'b1;
            end else if (takeTx)
                txHoldFull <= 1'b0;
            if (rxWrite) begin
                rxHold <= rxAged; // [RQ13]
                rxValid <= 1'b1;
            end else if (regRead && regAddr == `REG_RXDATA)
                rxValid <= 1'b0;
            if (txState == TX_SEND && byteStart && !txHoldFull && lastFlag)
                txDone <= 1'b1;
            else if (regRead && regAddr == `REG_STATUS)
                txDone <= 1'b0;
            // Active low request, inverted on the highway
            if (highwayMode)
                first_channel_tx_request <= txRequest; // [RQ10]
            else
                first_channel_tx_request <= !txRequest;
        end
    end

endmodule // tdm_slot_transparent_serial

// ==== hdl/tdm_slot_defines.vh ====
`ifndef TDM_SLOT_DEFINES_VH
`define TDM_SLOT_DEFINES_VH

// Register offsets
`define REG_MODE 4'h0
`define REG_CTRL 4'h1
`define REG_STATUS 4'h2
`define REG_TXDATA 4'h3
`define REG_RXDATA 4'h4
`define REG_MASK 4'h5

// Mode register fields
`define MODE_HIGHWAY 0
`define MODE_ENVELOPE 1
`define MODE_ROUTE_LO 2
`define MODE_ROUTE_HI 3
`define MODE_TSYNC 4
`define MODE_XSYNC 5
`define MODE_DIAG_LO 6
`define MODE_DIAG_HI 7

// Control register fields
`define CTRL_TXEN 0
`define CTRL_RXEN 1
`define CTRL_LAST 2

// Status register fields
`define ST_CARRIER 0
`define ST_CLEARSEND 1
`define ST_QUIET 2
`define ST_TXREQ 3
`define ST_TXRDY 4
`define ST_RXVALID 5
`define ST_TXDONE 6

// Reset values
`define MODE_RESET 8'h00
`define MASK_RESET 8'hff
`define IDLE_BYTE 8'hff

// Timing counts in slot clocks
`define REQ_DELAY_CLOCKS 6'd36
`define RX_WRITE_DELAY 4'd9
`define SLOT_BITS 4'd8

`endif

// ==== tb/tdm_slot_monitor.sv ====
`timescale 1ns/1ps
`include "tdm_slot_defines.vh"
module tdm_slot_monitor (
    input wire core_clk,
    input wire rst_n,
    input wire [3:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regRdata,
    input wire highway_bit_clock,
    input wire slot_select_low,
    input wire slot_select_high,
    input wire rxSerial,
    input wire txSerial,
    input wire first_channel_tx_request
);
    // ****
    // Shadow of mode and control
    // ****
    logic hw, txEn, rxEn, everTx, lastClk;
    logic [3:0] since;
    wire stRead = regRead && regAddr == `REG_STATUS;
    wire modeWr = regWrite && regAddr == `REG_MODE;
    wire ctrlWr = regWrite && regAddr == `REG_CTRL;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {hw, txEn, rxEn, everTx, lastClk} <= 5'h00;
            since <= 4'h0;
        end else begin
            lastClk <= highway_bit_clock;
            // Saturates so a stopped link clock never wraps
            since <= (highway_bit_clock && !lastClk) ? 4'h0 : since + {3'h0, since != 4'hf};
            if (modeWr) hw <= regWdata[`MODE_HIGHWAY];
            if (ctrlWr) begin
                txEn <= regWdata[`CTRL_TXEN];
                rxEn <= regWdata[`CTRL_RXEN];
                everTx <= everTx | regWdata[`CTRL_TXEN];
            end
        end
    end
    // ****
    // Assertions
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (regRead && regAddr > 4'h5 |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_quiet_zero: assert property (stRead |=> !regRdata[`ST_QUIET])
        else $error("quiet flag set");
    a_clearsend_zero: assert property (stRead && hw && txEn |=> !regRdata[`ST_CLEARSEND])
        else $error("clear-send set while transmitting");
    a_carrier_zero: assert property (stRead && hw && rxEn |=> !regRdata[`ST_CARRIER])
        else $error("carrier set while receiving");
    a_shift_timing: assert property ($changed(txSerial) |-> since inside {[1:6]})
        else $error("line moved without a link clock rise");
    a_request_polarity: assert property (modeWr && regWdata[0] && !txEn |-> ##3 !first_channel_tx_request)
        else $error("request not low after highway mode");
    a_idle_ones: assert property (!everTx |-> txSerial)
        else $error("line not idle high");
    c_request: cover property ($rose(first_channel_tx_request));
    c_tx_low: cover property ($fell(txSerial));
    c_rx_status: cover property (stRead && rxEn);
endmodule // tdm_slot_monitor

// ==== tb/highway_model.sv ====
`timescale 1ns/1ps
module highway_model (
    output logic highway_bit_clock,
    output logic slot_select_low,
    output logic slot_select_high,
    output logic rxSerial,
    input wire txSerial,
    input wire [7:0] rxByte
);
    // ****
    // Free running highway: 8-clock slot, 8-clock gap
    // ****
    logic [7:0] txq[$];
    logic [7:0] sh = 8'h00;
    int pos = 15;
    event slotEnd;
    initial begin
        {highway_bit_clock, slot_select_low, slot_select_high, rxSerial} = 4'h1;
        #7;
        forever #160 highway_bit_clock = ~highway_bit_clock;
    end
    // Selects move on the falling edge, clear of the sampling edge
    always @(negedge highway_bit_clock) begin
        pos = (pos + 1) % 16;
        {slot_select_high, slot_select_low} = pos < 8 ? 2'h1 : (pos < 12 ? 2'h2 : 2'h0);
        // Unselected line toggles rather than holding the last bit
        rxSerial = pos < 8 ? rxByte[7 - pos] : ~rxSerial;
    end
    always @(posedge highway_bit_clock) begin
        if (pos >= 1 && pos <= 8) sh = {sh[6:0], txSerial};
        if (pos == 8) begin
            txq.push_back(sh);
            -> slotEnd;
        end
    end
endmodule // highway_model

// ==== tb/test_tdm_slot_transparent_serial.sv ====
`timescale 1ns/1ps
`include "tdm_slot_defines.vh"
module test_tdm_slot_transparent_serial;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] rxByte = 8'h00;
    logic [7:0] data, got;
    logic [3:0] addr;
    wire [7:0] regRdata;
    wire linkClk, selLo, selHi, rxSerial, txSerial, txReq;
    integer seed = 32'hb6bd;
    integer fails = 0;
    integer samples_checked = 0;
    integer cycles = 0;
    integer i, k;
    tdm_slot_transparent_serial u_dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .highway_bit_clock(linkClk), .slot_select_low(selLo), .slot_select_high(selHi),
        .rxSerial(rxSerial), .txSerial(txSerial), .first_channel_tx_request(txReq));
    highway_model u_hw (.highway_bit_clock(linkClk), .slot_select_low(selLo),
        .slot_select_high(selHi), .rxSerial(rxSerial), .txSerial(txSerial), .rxByte(rxByte));
    // ****
    // Helpers
    // ****
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            fails++;
            finish_test();
        end
    end
    // Late start: leading byte begins mid-slot, so data straddles two slots
    function automatic logic [7:0] expTx(int slot, logic [7:0] d, bit late);
        if (late)
            return slot == 5 ? {4'hf, d[7:4]} : (slot == 6 ? {d[3:0], 4'hf} : `IDLE_BYTE);
        return slot == 6 ? d : `IDLE_BYTE;
    endfunction
    task check(input logic [7:0] act, input logic [7:0] exp);
        samples_checked++;
        if (act !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        @(posedge core_clk);
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        @(negedge core_clk);
        d = regRdata;
        @(posedge core_clk);
    endtask
    task slotGap;
        @(u_hw.slotEnd);
        @(posedge core_clk);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ****
    // Tests
    // ****
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(`REG_MODE, got);
        check(got, `MODE_RESET);
        rd(`REG_MASK, got);
        check(got, `MASK_RESET);
        for (i = 0; i < 4; i++) begin
            addr = 4'($random(seed)) | 4'h8;
            wr(addr, 8'($random(seed)));
            rd(addr, got);
            check(got, 8'h00);
        end
        rd(`REG_STATUS, got);
        check({7'h00, got[`ST_QUIET]}, 8'h00);
        $display("registers done");
        // Same start delay on every pass shows a repeatable start
        for (k = 0; k < 3; k++) begin
            wr(`REG_CTRL, 8'h00);
            // Normal, then software diagnostics, then plain line with no sync bits
            wr(`REG_MODE, k == 2 ? 8'h06 : (k == 1 ? 8'h77 : 8'h37));
            data = {1'b0, 7'($random(seed))};
            wr(`REG_TXDATA, data);
            slotGap();
            u_hw.txq.delete();
            wr(`REG_CTRL, 8'h05);
            rd(`REG_STATUS, got);
            if (k < 2) check({7'h00, got[`ST_CLEARSEND]}, 8'h00);
            check({7'h00, txReq ^ (k == 2)}, 8'h00);
            for (i = 0; i < 8; i++) begin
                @(u_hw.slotEnd);
                if (i == 3) check({7'h00, txReq ^ (k == 2)}, 8'h00);
                if (i == 5) check({7'h00, txReq ^ (k == 2)}, 8'h01);
                if (i == 7) check({7'h00, txReq ^ (k == 2)}, 8'h00);
            end
            for (i = 0; i < 8; i++)
                check(u_hw.txq[i], expTx(i, data, k == 2));
            rd(`REG_STATUS, got);
            check(got & 8'h58, 8'h50);
            $display("transmit pass %0d done", k);
        end
        wr(`REG_MODE, 8'h37);
        rxByte <= 8'($random(seed));
        slotGap();
        wr(`REG_CTRL, 8'h02);
        rd(`REG_STATUS, got);
        check({7'h00, got[`ST_CARRIER]}, 8'h00);
        repeat (2) @(u_hw.slotEnd);
        @(posedge core_clk);
        rd(`REG_STATUS, got);
        check({7'h00, got[`ST_RXVALID]}, 8'h00);
        slotGap();
        rd(`REG_STATUS, got);
        check({7'h00, got[`ST_RXVALID]}, 8'h01);
        rd(`REG_RXDATA, got);
        check(got, rxByte);
        $display("receive done");
        finish_test();
    end
endmodule // test_tdm_slot_transparent_serial
bind tdm_slot_transparent_serial tdm_slot_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .highway_bit_clock(highway_bit_clock),
    .slot_select_low(slot_select_low), .slot_select_high(slot_select_high),
    .rxSerial(rxSerial), .txSerial(txSerial),
    .first_channel_tx_request(first_channel_tx_request));
